// file: rtl/pdm_pkg.sv
// Constants and types for the power-down mode control block
package pdm_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_POWER_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_WAKE_ENABLE  = 12'h004;
  localparam logic [11:0] ADDR_STATUS       = 12'h008;
  // Field positions
  localparam int IDLE_BIT = 0;
  localparam int PD_BIT   = 1;
  localparam int GF0_BIT  = 2;
  localparam int GF1_BIT  = 3;
  localparam int WAKE_EN_ZERO_BIT = 0;
  localparam int WAKE_EN_ONE_BIT  = 1;
  // Reset values
  localparam logic [3:0] POWER_CONFIG_RESET = 4'h0;
  localparam logic [1:0] WAKE_ENABLE_RESET  = 2'h0;
  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int OSC_SETTLE_NS    = 2000;
  localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_NS        = 80;
  localparam int RESUME_CYCLES    = (RESUME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_SEQ_NS     = 160;
  localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COUNT_W          = 16;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
  localparam logic       HRESP_OKAY    = 1'b0;
  // Mode states, Gray along the usual path
  typedef enum logic [2:0] {
    PDM_RUN          = 3'b000,
    PDM_PD_STOP      = 3'b001,
    PDM_OSC_SETTLE   = 3'b011,
    PDM_WAIT_RELEASE = 3'b010,
    PDM_IDLE         = 3'b100,
    PDM_RST_RESUME   = 3'b101,
    PDM_RST_SEQ      = 3'b111
  } pdm_state_t;
endpackage

// file: rtl/pdm_top.sv
// Power-down mode controller with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module pdm_top #(
  parameter int OSC_SETTLE_CYCLES = pdm_pkg::OSC_SETTLE_CYCLES,
  parameter int RESUME_CYCLES     = pdm_pkg::RESUME_CYCLES,
  parameter int RESET_SEQ_CYCLES  = pdm_pkg::RESET_SEQ_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        reset_pin,
  input  wire logic        ext_irq_zero_n,
  input  wire logic        ext_irq_one_n,
  input  wire logic        other_irq,
  input  wire logic        ext_code,
  input  wire logic [7:0]  port0_data,
  input  wire logic [31:0] port14_data,
  input  wire logic        ale_run,
  input  wire logic        program_store_strobe_run_n,
  output var  logic        osc_enable,
  output var  logic        cpu_clk_enable,
  output var  logic        periph_clk_enable,
  output var  logic        cpu_run,
  output var  logic        state_retain,
  output var  logic        ram_access_block,
  output var  logic        sfr_reset,
  output var  logic        isr_request,
  output var  logic [7:0]  port0_out,
  output var  logic        port0_oe,
  output var  logic [31:0] port14_out,
  output var  logic        ale,
  output var  logic        program_store_strobe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pdm_pkg::pdm_state_t state;
  pdm_pkg::pdm_state_t next_state;
  logic [3:0]                  power_config_reg;
  logic [1:0]                  wake_enable;
  logic [1:0]                  wake_source;
  logic [1:0]                  next_wake_source;
  logic [pdm_pkg::COUNT_W-1:0] count;
  logic [pdm_pkg::COUNT_W-1:0] next_count;
  logic [1:0]                  reset_sync;
  logic                        reset_seen;
  logic                        wr_pending;
  logic [11:0]                 wr_addr;
  logic                        addr_phase;
  logic                        wr_commit;
  logic [1:0]                  wake_lines;
  logic                        hw_clear_bits;
  logic                        hw_clear_idle;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [pdm_pkg::COUNT_W-1:0] last_count(input int cycles);
    last_count = (cycles > 1) ? pdm_pkg::COUNT_W'(cycles - 1) : '0;
  endfunction

  function automatic logic is_stopped(input pdm_pkg::pdm_state_t s);
    is_stopped = (s == pdm_pkg::PDM_PD_STOP) || (s == pdm_pkg::PDM_OSC_SETTLE);
  endfunction

  assign reset_seen    = reset_sync[1];
  assign wake_lines    = {~ext_irq_one_n & wake_enable[pdm_pkg::WAKE_EN_ONE_BIT],
                          ~ext_irq_zero_n & wake_enable[pdm_pkg::WAKE_EN_ZERO_BIT]};
  assign addr_phase    = hsel && hready && htrans == pdm_pkg::HTRANS_NONSEQ;
  assign wr_commit     = wr_pending && hready;
  assign hw_clear_bits = (state == pdm_pkg::PDM_PD_STOP) && (next_state == pdm_pkg::PDM_OSC_SETTLE);
  assign hw_clear_idle = (state == pdm_pkg::PDM_IDLE) && (next_state == pdm_pkg::PDM_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_sync <= 2'b00;
    end else begin
      reset_sync <= {reset_sync[0], reset_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr    <= 12'h000;
    end else if (hready) begin
      wr_pending <= addr_phase && hwrite && hsize == pdm_pkg::HSIZE_WORD;
      wr_addr    <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= pdm_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= pdm_pkg::HRESP_OKAY;
      if (addr_phase && !hwrite) begin
        if (haddr[11:0] == pdm_pkg::ADDR_POWER_CONFIG) begin
          hrdata <= {28'h0000000, power_config_reg};
        end else if (haddr[11:0] == pdm_pkg::ADDR_WAKE_ENABLE) begin
          hrdata <= {30'h0, wake_enable};
        end else if (haddr[11:0] == pdm_pkg::ADDR_STATUS) begin
          hrdata <= {24'h000000, 1'b0, state, 2'b00, wake_source};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power configuration and wake enable registers
  always_ff @(posedge hclk or negedge hresetn or posedge reset_pin) begin
    if (!hresetn) begin
      power_config_reg <= pdm_pkg::POWER_CONFIG_RESET;
    end else if (reset_pin) begin
      power_config_reg <= pdm_pkg::POWER_CONFIG_RESET;
    end else begin
      if (hw_clear_bits) begin
        power_config_reg[pdm_pkg::PD_BIT]   <= 1'b0;
        power_config_reg[pdm_pkg::IDLE_BIT] <= 1'b0;
      end
      if (hw_clear_idle) begin
        power_config_reg[pdm_pkg::IDLE_BIT] <= 1'b0;
      end
      if (next_state == pdm_pkg::PDM_RST_SEQ) begin
        power_config_reg <= pdm_pkg::POWER_CONFIG_RESET;
      end else if (wr_commit && wr_addr == pdm_pkg::ADDR_POWER_CONFIG && state == pdm_pkg::PDM_RUN) begin
        power_config_reg <= hwdata[3:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_enable <= pdm_pkg::WAKE_ENABLE_RESET;
    end else if (next_state == pdm_pkg::PDM_RST_SEQ) begin
      wake_enable <= pdm_pkg::WAKE_ENABLE_RESET;
    end else if (wr_commit && wr_addr == pdm_pkg::ADDR_WAKE_ENABLE) begin
      wake_enable <= hwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine
  always_comb begin
    next_state       = state;
    next_count       = count;
    next_wake_source = wake_source;
    case (state)
      pdm_pkg::PDM_RUN: begin
        next_count = '0;
        if (reset_seen) begin
          next_state = pdm_pkg::PDM_RST_SEQ;
        end else if (power_config_reg[pdm_pkg::PD_BIT]) begin
          next_state = pdm_pkg::PDM_PD_STOP;
        end else if (power_config_reg[pdm_pkg::IDLE_BIT]) begin
          next_state = pdm_pkg::PDM_IDLE;
        end
      end
      pdm_pkg::PDM_IDLE: begin
        if (reset_seen) begin
          next_state = pdm_pkg::PDM_RST_SEQ;
        end else if (other_irq || wake_lines != 2'b00) begin
          next_state = pdm_pkg::PDM_RUN;
        end
      end
      pdm_pkg::PDM_PD_STOP: begin
        next_count = '0;
        if (reset_seen) begin
          next_state = pdm_pkg::PDM_RST_RESUME;
        end else if (wake_lines != 2'b00) begin
          next_state       = pdm_pkg::PDM_OSC_SETTLE;
          next_wake_source = wake_lines;
        end
      end
      pdm_pkg::PDM_OSC_SETTLE: begin
        next_count = count + 1'b1;
        if (reset_seen) begin
          next_state = pdm_pkg::PDM_RST_RESUME;
          next_count = '0;
        end else if (count >= last_count(OSC_SETTLE_CYCLES)) begin
          next_state = pdm_pkg::PDM_WAIT_RELEASE;
          next_count = '0;
        end
      end
      pdm_pkg::PDM_WAIT_RELEASE: begin
        if (reset_seen) begin
          next_state = pdm_pkg::PDM_RST_RESUME;
        end else if ((wake_source & {~ext_irq_one_n, ~ext_irq_zero_n}) == 2'b00) begin
          next_state = pdm_pkg::PDM_RUN;
        end
      end
      pdm_pkg::PDM_RST_RESUME: begin
        next_count = count + 1'b1;
        if (count >= last_count(RESUME_CYCLES)) begin
          next_state = pdm_pkg::PDM_RST_SEQ;
          next_count = '0;
        end
      end
      pdm_pkg::PDM_RST_SEQ: begin
        next_wake_source = 2'b00;
        if (count < last_count(RESET_SEQ_CYCLES)) begin
          next_count = count + 1'b1;
        end else if (!reset_seen) begin
          next_state = pdm_pkg::PDM_RUN;
          next_count = '0;
        end
      end
      default: begin
        next_state = pdm_pkg::PDM_RUN;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= pdm_pkg::PDM_RUN;
      count       <= '0;
      wake_source <= 2'b00;
    end else begin
      state       <= next_state;
      count       <= next_count;
      wake_source <= next_wake_source;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock, retention and core control outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_enable        <= 1'b1;
      cpu_clk_enable    <= 1'b1;
      periph_clk_enable <= 1'b1;
      cpu_run           <= 1'b1;
      state_retain      <= 1'b0;
      ram_access_block  <= 1'b0;
      sfr_reset         <= 1'b0;
      isr_request       <= 1'b0;
    end else begin
      osc_enable        <= next_state != pdm_pkg::PDM_PD_STOP;
      cpu_clk_enable    <= !is_stopped(next_state) && next_state != pdm_pkg::PDM_IDLE;
      periph_clk_enable <= !is_stopped(next_state);
      cpu_run           <= next_state == pdm_pkg::PDM_RUN || next_state == pdm_pkg::PDM_RST_RESUME;
      state_retain      <= is_stopped(next_state) || next_state == pdm_pkg::PDM_WAIT_RELEASE;
      ram_access_block  <= next_state == pdm_pkg::PDM_RST_RESUME;
      sfr_reset         <= next_state == pdm_pkg::PDM_RST_SEQ;
      isr_request       <= state == pdm_pkg::PDM_WAIT_RELEASE && next_state == pdm_pkg::PDM_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port0_out              <= 8'hff;
      port0_oe               <= 1'b0;
      port14_out             <= 32'hffff_ffff;
      ale                    <= 1'b1;
      program_store_strobe_n <= 1'b1;
    end else begin
      port0_out  <= port0_data;
      port14_out <= port14_data;
      if (next_state == pdm_pkg::PDM_RST_SEQ) begin
        port0_oe               <= 1'b0;
        port14_out             <= 32'hffff_ffff;
        ale                    <= 1'b1;
        program_store_strobe_n <= 1'b1;
      end else if (next_state == pdm_pkg::PDM_IDLE) begin
        port0_oe               <= !ext_code;
        ale                    <= 1'b1;
        program_store_strobe_n <= 1'b1;
      end else if (state_retain || is_stopped(next_state)) begin
        port0_oe               <= !ext_code;
        ale                    <= 1'b0;
        program_store_strobe_n <= 1'b0;
      end else begin
        port0_oe               <= 1'b1;
        ale                    <= ale_run;
        program_store_strobe_n <= program_store_strobe_run_n;
      end
    end
  end

endmodule
`default_nettype wire

// file: bench/pdm_properties.sv
// Assertions on the power-down controller ports
`timescale 1ns/1ps
`default_nettype none
module pdm_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        reset_pin,
  input wire logic        ext_irq_zero_n,
  input wire logic        ext_irq_one_n,
  input wire logic        osc_enable,
  input wire logic        cpu_clk_enable,
  input wire logic        cpu_run,
  input wire logic        state_retain,
  input wire logic        ram_access_block,
  input wire logic        sfr_reset,
  input wire logic        isr_request,
  input wire logic        port0_oe,
  input wire logic [31:0] port14_out,
  input wire logic        ale,
  input wire logic        program_store_strobe_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////
  sequence quiet_stop;
    !osc_enable && ext_irq_zero_n && ext_irq_one_n && !reset_pin;
  endsequence
  sequence settle_then_clock;
    !cpu_clk_enable[*3] ##[1:4] cpu_clk_enable;
  endsequence
  chk_pd_pins_low: assert property (!osc_enable |-> !cpu_clk_enable && !ale && !program_store_strobe_n && state_retain)
    else $error("power-down outputs wrong");
  chk_no_stray_wake: assert property (quiet_stop[*6] |=> !osc_enable)
    else $error("woke without enabled line");
  chk_run_on_release: assert property ($rose(cpu_run) && isr_request |-> $past(ext_irq_zero_n, 1) && $past(ext_irq_one_n, 1))
    else $error("resumed before line release");
  chk_isr_one_pulse: assert property (isr_request |-> cpu_run && osc_enable && cpu_clk_enable ##1 !isr_request)
    else $error("service request pulse wrong");
  chk_settle_clock: assert property ($rose(osc_enable) && state_retain |-> settle_then_clock)
    else $error("clock restore after settle wrong");
  chk_ram_block_seq: assert property ($rose(ram_access_block) |-> cpu_run ##0 ram_access_block[*2] ##[1:2] sfr_reset)
    else $error("post-reset execution window wrong");
  chk_reset_synced: assert property ($rose(reset_pin) |-> !sfr_reset[*2] ##[1:8] sfr_reset)
    else $error("reset sequence timing wrong");
  chk_reset_pins: assert property (sfr_reset |-> !port0_oe && (&port14_out) && ale && program_store_strobe_n)
    else $error("reset pin states wrong");
endmodule
bind pdm_top pdm_properties pdm_properties_i (.hclk, .hresetn, .reset_pin, .ext_irq_zero_n, .ext_irq_one_n,
  .osc_enable, .cpu_clk_enable, .cpu_run, .state_retain, .ram_access_block, .sfr_reset, .isr_request,
  .port0_oe, .port14_out, .ale, .program_store_strobe_n);
`default_nettype wire

// file: bench/pdm_partner.sv
// External interrupt lines and reset pin driver
`timescale 1ns/1ps
`default_nettype none
module pdm_partner (
  input  wire logic hclk,
  output var  logic ext_irq_zero_n,
  output var  logic ext_irq_one_n,
  output var  logic reset_pin
);
  initial begin
    ext_irq_zero_n = 1'b1;
    ext_irq_one_n  = 1'b1;
    reset_pin      = 1'b0;
  end
  // Low level held for n cycles, then both lines back to pull-up
  task automatic irq_low(input int line, input int n);
    @(posedge hclk);
    if (line == 0) ext_irq_zero_n <= 1'b0;
    else ext_irq_one_n <= 1'b0;
    repeat (n) @(posedge hclk);
    ext_irq_zero_n <= 1'b1;
    ext_irq_one_n  <= 1'b1;
  endtask
  task automatic rst_high(input int n);
    @(posedge hclk);
    reset_pin <= 1'b1;
    repeat (n) @(posedge hclk);
    reset_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: bench/pdm_top_tb.sv
// Self-checking bench for the power-down controller
`timescale 1ns/1ps
`default_nettype none
module pdm_top_tb;
  logic        hclk, hresetn, hwrite, hreadyout, other_irq, ext_code;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, port14_data, port14_out;
  logic [7:0]  port0_data, port0_out;
  logic        osc_enable, cpu_clk_enable, cpu_run, isr_request, ram_access_block, sfr_reset;
  logic        port0_oe, ale, program_store_strobe_n, hresp, periph_clk_enable, state_retain, ale_run, strobe_run_n;
  wire logic   irq0_n, irq1_n, rst_pin;
  int          n_mismatch, cmp_count, seed, mdl_cfg, mdl_wen;
  pdm_partner pdm_partner_i (.hclk(hclk), .ext_irq_zero_n(irq0_n), .ext_irq_one_n(irq1_n), .reset_pin(rst_pin));
  pdm_top #(.OSC_SETTLE_CYCLES(4), .RESUME_CYCLES(2), .RESET_SEQ_CYCLES(2)) pdm_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(pdm_pkg::HSIZE_WORD), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reset_pin(rst_pin), .ext_irq_zero_n(irq0_n), .ext_irq_one_n(irq1_n), .other_irq(other_irq),
    .ext_code(ext_code), .port0_data(port0_data), .port14_data(port14_data), .ale_run(ale_run),
    .program_store_strobe_run_n(strobe_run_n), .osc_enable(osc_enable), .cpu_clk_enable(cpu_clk_enable),
    .periph_clk_enable(periph_clk_enable), .cpu_run(cpu_run), .state_retain(state_retain),
    .ram_access_block(ram_access_block),
    .sfr_reset(sfr_reset), .isr_request(isr_request), .port0_out(port0_out), .port0_oe(port0_oe),
    .port14_out(port14_out), .ale(ale), .program_store_strobe_n(program_store_strobe_n));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return hreadyout;
      1: return osc_enable;
      2: return cpu_clk_enable;
      3: return isr_request;
      4: return ram_access_block;
      default: return sfr_reset;
    endcase
  endfunction
  task automatic till(input int k, input logic v);
    for (int i = 0; i < 400; i++) begin
      @(posedge hclk);
      if (pick(k) === v) return;
    end
    chk("wait", 32'h1, 32'h0);
    wrap_up();
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= pdm_pkg::HTRANS_NONSEQ;
    till(0, 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    till(0, 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a == pdm_pkg::ADDR_POWER_CONFIG) mdl_cfg = d & 32'hf;
    if (a == pdm_pkg::ADDR_WAKE_ENABLE) mdl_wen = d & 32'h3;
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q & m);
    chk("resp", pdm_pkg::HRESP_OKAY, hresp);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    {hresetn, haddr, htrans, hwrite, hwdata, other_irq, ext_code} = '0;
    seed = $urandom(32'hd25e0592);
    port0_data = 8'($urandom);
    port14_data = $urandom;
    ale_run = 1'($urandom);
    strobe_run_n = 1'($urandom);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd("cfg", pdm_pkg::ADDR_POWER_CONFIG, mdl_cfg, 32'hffffffff);
    rd("wen", pdm_pkg::ADDR_WAKE_ENABLE, mdl_wen, 32'hffffffff);
    rd("gap", 12'h00c, 32'h0, 32'hffffffff);
    wr(pdm_pkg::ADDR_WAKE_ENABLE, 32'h1);
    chk("p14", port14_data, port14_out);
    chk("ale", ale_run, ale);
    chk("pse", strobe_run_n, program_store_strobe_n);
    chk("oe", 32'h1, port0_oe);
    $display("test registers done");
    wr(pdm_pkg::ADDR_POWER_CONFIG, ($urandom & 32'hc) | 32'h3);
    till(1, 1'b0);
    rd("state", pdm_pkg::ADDR_STATUS, {pdm_pkg::PDM_PD_STOP, 4'h0}, 32'h70);
    chk("p0", port0_data, port0_out);
    chk("p14", port14_data, port14_out);
    chk("ale", 32'h0, ale);
    chk("oe", 32'h1, port0_oe);
    chk("pclk", 32'h0, periph_clk_enable);
    chk("hold", 32'h1, state_retain);
    fork
      pdm_partner_i.irq_low(1, 12);
      begin
        other_irq <= 1'b1;
        @(posedge hclk);
        other_irq <= 1'b0;
      end
    join
    chk("osc", 32'h0, osc_enable);
    fork
      pdm_partner_i.irq_low(0, 30);
      begin
        till(1, 1'b1);
        mdl_cfg = mdl_cfg & 32'hc;
        rd("cfg", pdm_pkg::ADDR_POWER_CONFIG, mdl_cfg, 32'hf);
        chk("run", 32'h0, cpu_run);
        till(3, 1'b1);
        chk("run", 32'h1, cpu_run);
        chk("pclk", 32'h1, periph_clk_enable);
        chk("hold", 32'h0, state_retain);
      end
    join
    $display("test interrupt wake done");
    ext_code <= 1'b1;
    wr(pdm_pkg::ADDR_POWER_CONFIG, 32'h1);
    till(2, 1'b0);
    @(posedge hclk);
    chk("ale", 32'h1, ale);
    chk("oe", 32'h0, port0_oe);
    other_irq <= 1'b1;
    till(2, 1'b1);
    other_irq <= 1'b0;
    ext_code <= 1'b0;
    mdl_cfg = mdl_cfg & 32'hc;
    rd("cfg", pdm_pkg::ADDR_POWER_CONFIG, mdl_cfg, 32'hf);
    $display("test idle done");
    wr(pdm_pkg::ADDR_WAKE_ENABLE, 32'h3);
    wr(pdm_pkg::ADDR_POWER_CONFIG, 32'h2);
    till(1, 1'b0);
    mdl_cfg = 0;
    fork
      pdm_partner_i.rst_high(20);
      begin
        till(4, 1'b1);
        chk("run", 32'h1, cpu_run);
        rd("cfg", pdm_pkg::ADDR_POWER_CONFIG, mdl_cfg, 32'hf);
        till(5, 1'b1);
        chk("strobe", 32'h1, program_store_strobe_n);
      end
    join
    till(5, 1'b0);
    mdl_wen = 0;
    rd("wen", pdm_pkg::ADDR_WAKE_ENABLE, mdl_wen, 32'hffffffff);
    $display("test reset wake done");
    wrap_up();
  end
endmodule
`default_nettype wire
